// ### core/limg_pkg.sv
// Constants and types of the link interrupt mask gate
package limg_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_ENABLE_MASK_SET = 8'h88;
  localparam logic [7:0] OFS_IRQ_ENABLE_MASK_CLEAR = 8'h8c;
  localparam logic [7:0] OFS_IRQ_GATE_CTRL = 8'h90;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h94;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_IRQ_GATE = 31;
  localparam int BIT_DEVICE_SPECIFIC_IRQ = 30;
  localparam int BIT_SOFTWARE_TRIGGERED_IRQ = 29;
  localparam int BIT_CTRL_AUTO_DROP = 0;
  // Event source positions, shared by event and mask words
  localparam int POS_DEVICE_IRQ = 30;
  localparam int POS_SOFT_IRQ = 29;
  localparam int POS_LATE_ACK = 27;
  localparam int POS_PHY_REG_RX = 26;
  localparam int POS_OVERLONG = 25;
  localparam int POS_FATAL = 24;
  localparam int POS_CYC_INCONS = 23;
  localparam int POS_CYC_MISSED = 22;
  localparam int POS_ROLL64 = 21;
  localparam int POS_CYC_START = 20;
  localparam int POS_PHY_STATUS = 19;
  localparam int POS_REG_FAIL = 18;
  localparam int POS_BUS_RESET = 17;
  localparam int POS_IDENT_DONE = 16;
  localparam int POS_IDENT_STICKY = 15;
  localparam int POS_LOCK_ERR = 9;
  localparam int POS_POSTED_ERR = 8;
  localparam int POS_ISO_RX = 7;
  localparam int POS_ISO_TX = 6;
  localparam int POS_RESP_PKT = 5;
  localparam int POS_REQ_PKT = 4;
  localparam int POS_ARX_RESP = 3;
  localparam int POS_ARX_REQ = 2;
  localparam int POS_RESP_DONE = 1;
  localparam int POS_REQ_DONE = 0;
  // Writable mask bits: all but 28 and 14..10
  localparam logic [31:0] MASK_IMPL = 32'hefff_83ff;
  // Bits 15..12 come out of reset at zero, as do all the rest
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
  localparam logic WAITREQ_RESET = 1'b1;
  localparam logic AUTO_DROP_RESET = 1'b0;
  localparam logic IRQ_RESET = 1'b0;
  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    LIMG_IDLE = 1'b0,
    LIMG_DONE = 1'b1
  } limg_bus_e;
  typedef struct packed {
    limg_bus_e bus;
    logic waitreq;
    logic [31:0] mask;
    logic auto_drop;
    logic [31:0] readdata;
    logic irq;
  } limg_state_s;
endpackage

// ### core/limg_top.sv
// Interrupt mask register with master gate and Avalon-MM slave
`timescale 1ns/1ps
// Overview of operation
// - Reads at set or clear offset return the mask, without side effects.
// - Ones written at set offset set bits; at clear offset clear bits.
// - Master enable bit 31 low blocks the interrupt output entirely.
// - Mask bits below 30 line up with matching event bits.
// - Bit 30 enables the device-specific source with event bit 30.
// - Bit 29 enables the software-triggered source with event bit 29.
// - Bit 28 reads zero and ignores writes.
// - Bits 14 to 10 read zero and ignore writes.
// - Bits 27 and 26 gate late-ack and phys-register-received events.
// - Bits 25 and 24 gate overlong-cycle and fatal-error events.
// - Bits 23 and 22 gate inconsistent-cycle-time and missed-cycle events.
// - Bits 21 and 20 gate rollover and iso-cycle-start events.
// - Bits 19 and 18 gate phy status and register-access-failed events.
// - Bits 17, 16, 15 gate bus reset and node-ident-done events.
// - Bits 9 and 8 gate lock response and posted write errors.
// - Bits 7 and 6 gate iso receive and transmit summaries.
// - Bits 5 and 4 gate response and request packet received.
// - Bits 3 and 2 gate async receive response and request DMA.
// - Bits 1 and 0 gate response and request transmit done.
// - Master enable may also be changed by hardware update.
// - Bits 15 to 12 read zero after reset.
module limg_top #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] irq_event,
  input wire logic hw_gate_set,
  input wire logic hw_gate_clear,
  output logic irq_out
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 32) begin : g_chk_data_w
    $error("limg_top: DATA_W must be 32");
  end
  if (ADDR_W != 8) begin : g_chk_addr_w
    $error("limg_top: ADDR_W must be 8");
  end

  // ----------------------------------------------------------------
  // State and decoded signals
  // ----------------------------------------------------------------
  limg_pkg::limg_state_s st;
  limg_pkg::limg_state_s next_st;
  logic [31:0] wmask;
  logic [31:0] pending;
  logic sw_take;
  logic [31:0] rd_word;

  // Device-specific source
  logic device_specific_irq_hit;

  // Software-triggered source
  logic software_triggered_irq_hit;

  // Late acknowledge
  logic late_ack_hit;
  // Phy register received
  logic phys_register_received_hit;

  // Overlong cycle
  logic overlong_cycle_hit;
  // Fatal error
  logic fatal_error_hit;

  // Inconsistent cycle time
  logic inconsistent_cycle_time_hit;
  // Missed cycle
  logic missed_cycle_hit;

  // Rollover of the seconds count
  logic sixty_four_second_rollover_hit;
  // Cycle start
  logic iso_cycle_start_hit;

  // Phy status transfer
  logic phy_status_transfer_hit;
  // Failed register access
  logic register_access_failed_hit;

  // Bus reset
  logic serial_bus_reset_hit;
  // Node identification done
  logic node_ident_done_hit;
  // Node identification done, kept
  logic node_ident_done_sticky_hit;

  // Lock response error
  logic lock_response_error_hit;
  // Posted write error
  logic posted_write_error_hit;

  // Receive summary
  logic iso_receive_summary_hit;
  // Transmit summary
  logic iso_transmit_summary_hit;

  // Response packet received
  logic response_packet_received_hit;
  // Request packet received
  logic request_packet_received_hit;

  // Receive response DMA
  logic async_rx_response_dma_hit;
  // Receive request DMA
  logic async_rx_request_dma_hit;

  // Response transmit done
  logic response_transmit_done_hit;
  // Request transmit done
  logic request_transmit_done_hit;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // One source: event and its enable both set
  function automatic logic src_hit(input logic [31:0] ev,
                                   input logic [31:0] mk,
                                   input int pos);
    src_hit = ev[pos] & mk[pos];
  endfunction

  function automatic logic is_mask_ofs(input logic [7:0] a);
    is_mask_ofs = (a == limg_pkg::OFS_IRQ_ENABLE_MASK_SET) ||
                  (a == limg_pkg::OFS_IRQ_ENABLE_MASK_CLEAR);
  endfunction

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    if (is_mask_ofs(avs_address)) begin
      rd_word = st.mask & limg_pkg::MASK_IMPL;
    end else if (avs_address == limg_pkg::OFS_IRQ_GATE_CTRL) begin
      rd_word = {31'h0000_0000, st.auto_drop};
    end else if (avs_address == limg_pkg::OFS_IRQ_STATUS) begin
      rd_word = pending;
    end else begin
      rd_word = limg_pkg::READ_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------
  // Device-specific source
  // ----------------------------------------------------------------
  assign device_specific_irq_hit = src_hit(irq_event, st.mask, limg_pkg::POS_DEVICE_IRQ);

  // ----------------------------------------------------------------
  // Software-triggered source
  // ----------------------------------------------------------------
  assign software_triggered_irq_hit = src_hit(irq_event, st.mask, limg_pkg::POS_SOFT_IRQ);

  // ----------------------------------------------------------------
  // Late acknowledge, phy register
  // ----------------------------------------------------------------
  assign late_ack_hit = src_hit(irq_event, st.mask, limg_pkg::POS_LATE_ACK);
  assign phys_register_received_hit = src_hit(irq_event, st.mask, limg_pkg::POS_PHY_REG_RX);

  // ----------------------------------------------------------------
  // Overlong cycle, fatal error
  // ----------------------------------------------------------------
  assign overlong_cycle_hit = src_hit(irq_event, st.mask, limg_pkg::POS_OVERLONG);
  assign fatal_error_hit = src_hit(irq_event, st.mask, limg_pkg::POS_FATAL);

  // ----------------------------------------------------------------
  // Cycle timing faults
  // ----------------------------------------------------------------
  assign inconsistent_cycle_time_hit = src_hit(irq_event, st.mask, limg_pkg::POS_CYC_INCONS);
  assign missed_cycle_hit = src_hit(irq_event, st.mask, limg_pkg::POS_CYC_MISSED);

  // ----------------------------------------------------------------
  // Cycle timer
  // ----------------------------------------------------------------
  assign sixty_four_second_rollover_hit = src_hit(irq_event, st.mask, limg_pkg::POS_ROLL64);
  assign iso_cycle_start_hit = src_hit(irq_event, st.mask, limg_pkg::POS_CYC_START);

  // ----------------------------------------------------------------
  // Phy status, register access
  // ----------------------------------------------------------------
  assign phy_status_transfer_hit = src_hit(irq_event, st.mask, limg_pkg::POS_PHY_STATUS);
  assign register_access_failed_hit = src_hit(irq_event, st.mask, limg_pkg::POS_REG_FAIL);

  // ----------------------------------------------------------------
  // Bus reset, node identification
  // ----------------------------------------------------------------
  assign serial_bus_reset_hit = src_hit(irq_event, st.mask, limg_pkg::POS_BUS_RESET);
  assign node_ident_done_hit = src_hit(irq_event, st.mask, limg_pkg::POS_IDENT_DONE);
  assign node_ident_done_sticky_hit = src_hit(irq_event, st.mask, limg_pkg::POS_IDENT_STICKY);

  // ----------------------------------------------------------------
  // Write errors
  // ----------------------------------------------------------------
  assign lock_response_error_hit = src_hit(irq_event, st.mask, limg_pkg::POS_LOCK_ERR);
  assign posted_write_error_hit = src_hit(irq_event, st.mask, limg_pkg::POS_POSTED_ERR);

  // ----------------------------------------------------------------
  // Isochronous summaries
  // ----------------------------------------------------------------
  assign iso_receive_summary_hit = src_hit(irq_event, st.mask, limg_pkg::POS_ISO_RX);
  assign iso_transmit_summary_hit = src_hit(irq_event, st.mask, limg_pkg::POS_ISO_TX);

  // ----------------------------------------------------------------
  // Received packets
  // ----------------------------------------------------------------
  assign response_packet_received_hit = src_hit(irq_event, st.mask, limg_pkg::POS_RESP_PKT);
  assign request_packet_received_hit = src_hit(irq_event, st.mask, limg_pkg::POS_REQ_PKT);

  // ----------------------------------------------------------------
  // Receive DMA
  // ----------------------------------------------------------------
  assign async_rx_response_dma_hit = src_hit(irq_event, st.mask, limg_pkg::POS_ARX_RESP);
  assign async_rx_request_dma_hit = src_hit(irq_event, st.mask, limg_pkg::POS_ARX_REQ);

  // ----------------------------------------------------------------
  // Transmit completion
  // ----------------------------------------------------------------
  assign response_transmit_done_hit = src_hit(irq_event, st.mask, limg_pkg::POS_RESP_DONE);
  assign request_transmit_done_hit = src_hit(irq_event, st.mask, limg_pkg::POS_REQ_DONE);

  // ----------------------------------------------------------------
  // Pending word, gate and reserved positions left at zero
  // ----------------------------------------------------------------
  always_comb begin
    pending = limg_pkg::READ_UNMAPPED;

    // Vendor and software sources
    pending[limg_pkg::POS_DEVICE_IRQ] = device_specific_irq_hit;
    pending[limg_pkg::POS_SOFT_IRQ] = software_triggered_irq_hit;

    // Link and cycle sources
    pending[limg_pkg::POS_LATE_ACK] = late_ack_hit;
    pending[limg_pkg::POS_PHY_REG_RX] = phys_register_received_hit;
    pending[limg_pkg::POS_OVERLONG] = overlong_cycle_hit;
    pending[limg_pkg::POS_FATAL] = fatal_error_hit;
    pending[limg_pkg::POS_CYC_INCONS] = inconsistent_cycle_time_hit;
    pending[limg_pkg::POS_CYC_MISSED] = missed_cycle_hit;
    pending[limg_pkg::POS_ROLL64] = sixty_four_second_rollover_hit;
    pending[limg_pkg::POS_CYC_START] = iso_cycle_start_hit;

    // Phy and bus sources
    pending[limg_pkg::POS_PHY_STATUS] = phy_status_transfer_hit;
    pending[limg_pkg::POS_REG_FAIL] = register_access_failed_hit;
    pending[limg_pkg::POS_BUS_RESET] = serial_bus_reset_hit;
    pending[limg_pkg::POS_IDENT_DONE] = node_ident_done_hit;
    pending[limg_pkg::POS_IDENT_STICKY] = node_ident_done_sticky_hit;

    // Error sources
    pending[limg_pkg::POS_LOCK_ERR] = lock_response_error_hit;
    pending[limg_pkg::POS_POSTED_ERR] = posted_write_error_hit;

    // DMA summaries and packets
    pending[limg_pkg::POS_ISO_RX] = iso_receive_summary_hit;
    pending[limg_pkg::POS_ISO_TX] = iso_transmit_summary_hit;
    pending[limg_pkg::POS_RESP_PKT] = response_packet_received_hit;
    pending[limg_pkg::POS_REQ_PKT] = request_packet_received_hit;
    pending[limg_pkg::POS_ARX_RESP] = async_rx_response_dma_hit;
    pending[limg_pkg::POS_ARX_REQ] = async_rx_request_dma_hit;

    // Transmit completion
    pending[limg_pkg::POS_RESP_DONE] = response_transmit_done_hit;
    pending[limg_pkg::POS_REQ_DONE] = request_transmit_done_hit;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    wmask = avs_writedata & lane_mask(avs_byteenable) & limg_pkg::MASK_IMPL;
    sw_take = (st.bus == limg_pkg::LIMG_IDLE) && (avs_read || avs_write);
    next_st = st;
    next_st.bus = limg_pkg::LIMG_IDLE;

    // Software access, answered one cycle after it is taken
    if (sw_take) begin
      next_st.bus = limg_pkg::LIMG_DONE;
      if (avs_write) begin
        if (avs_address == limg_pkg::OFS_IRQ_ENABLE_MASK_SET) begin
          next_st.mask = st.mask | wmask;
        end else if (avs_address == limg_pkg::OFS_IRQ_ENABLE_MASK_CLEAR) begin
          next_st.mask = st.mask & ~wmask;
        end else if (avs_address == limg_pkg::OFS_IRQ_GATE_CTRL) begin
          if (avs_byteenable[0]) begin
            next_st.auto_drop = avs_writedata[limg_pkg::BIT_CTRL_AUTO_DROP];
          end
        end
        next_st.readdata = limg_pkg::READ_UNMAPPED;
      end else begin
        next_st.readdata = rd_word;
      end
    end

    // Hardware update of the master gate, after software so it wins
    if (hw_gate_set) begin
      next_st.mask[limg_pkg::BIT_GLOBAL_IRQ_GATE] = 1'b1;
    end else if (hw_gate_clear || (st.auto_drop && st.irq)) begin
      next_st.mask[limg_pkg::BIT_GLOBAL_IRQ_GATE] = 1'b0;
    end
    next_st.mask = next_st.mask & limg_pkg::MASK_IMPL;

    // Answer strobe kept in its own flip-flop
    next_st.waitreq = (next_st.bus != limg_pkg::LIMG_DONE);

    // Level interrupt from the mask about to be stored
    next_st.irq = next_st.mask[limg_pkg::BIT_GLOBAL_IRQ_GATE] &&
                  (|(irq_event[30:0] & next_st.mask[30:0]));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st.bus <= limg_pkg::LIMG_IDLE;
      st.waitreq <= limg_pkg::WAITREQ_RESET;
      st.mask <= limg_pkg::MASK_RESET;
      st.auto_drop <= limg_pkg::AUTO_DROP_RESET;
      st.readdata <= limg_pkg::READ_UNMAPPED;
      st.irq <= limg_pkg::IRQ_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each a stored bit
  // ----------------------------------------------------------------
  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitreq;
  assign irq_out = st.irq;
endmodule

// ### verification/limg_chk_sva.sv
// Assertion checker for the interrupt mask gate
`timescale 1ns/1ps
module limg_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [31:0] irq_event,
  input wire logic hw_gate_set,
  input wire logic hw_gate_clear,
  input wire logic irq_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait");
  chk_take_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("answer");
  chk_answer_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("cause");
  chk_rsvd_zero: assert property (avs_readdata[28] == 1'b0 && avs_readdata[14:10] == 5'h00)
    else $error("rsvd");
  chk_gate_off: assert property (hw_gate_clear && !hw_gate_set |=> !irq_out) else $error("gate");
  chk_no_event: assert property (irq_event[30:0] == 31'h0 |=> !irq_out) else $error("idle");
  chk_rdata_hold: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("hold");
  chk_reset_state: assert property (disable iff (1'b0) sys_rst |=> avs_waitrequest && !irq_out)
    else $error("reset");
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the interrupt mask gate
`timescale 1ns/1ps
module tb_top;
  logic clk = 0;
  logic sys_rst = 1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] irq_event = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic hw_gate_set = 0;
  logic hw_gate_clear = 0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq_out;
  logic [31:0] rdat;
  int err_total = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  limg_top i_dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_event, .hw_gate_set,
    .hw_gate_clear, .irq_out);
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      wrap_up();
    end
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk("readdata", e, rdat);
  endtask
  task automatic irq(input logic e);
    repeat (2) @(posedge clk);
    chk("irq_out", {31'h0, e}, {31'h0, irq_out});
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(8'h88, 32'h0000_0000);
    acc(1'b1, 8'h88, 32'hffff_ffff);
    rd(8'h8c, limg_pkg::MASK_IMPL);
    acc(1'b1, 8'h8c, 32'h8000_0000);
    rd(8'h88, limg_pkg::MASK_IMPL & 32'h7fff_ffff);
    irq_event <= 32'h7fff_ffff;
    irq(1'b0);
    hw_gate_set <= 1'b1;
    irq(1'b1);
    hw_gate_set <= 1'b0;
    hw_gate_clear <= 1'b1;
    irq(1'b0);
    hw_gate_clear <= 1'b0;
    acc(1'b1, 8'h88, 32'h8000_0000);
    for (int i = 0; i < 31; i++) begin
      irq_event <= 32'h0000_0001 << i;
      irq(limg_pkg::MASK_IMPL[i]);
      acc(1'b1, 8'h8c, 32'h0000_0001 << i);
      irq(1'b0);
      acc(1'b1, 8'h88, 32'h0000_0001 << i);
    end
    irq_event <= 32'h0000_0000;
    acc(1'b1, 8'h40, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    rd(8'h8c, limg_pkg::MASK_IMPL & 32'hefff_ffff);
    avs_byteenable <= 4'h1;
    acc(1'b1, 8'h8c, 32'hffff_ffff);
    avs_byteenable <= 4'hf;
    rd(8'h88, limg_pkg::MASK_IMPL & 32'hffff_ff00);
    irq_event <= 32'h0000_0101;
    rd(8'h94, 32'h0000_0100);
    irq(1'b1);
    acc(1'b1, 8'h90, 32'h0000_0001);
    rd(8'h90, 32'h0000_0001);
    rd(8'h88, limg_pkg::MASK_IMPL & 32'h7fff_ff00);
    irq(1'b0);
    wrap_up();
  end
endmodule
bind limg_top limg_chk i_chk (.clk, .sys_rst, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .irq_event, .hw_gate_set, .hw_gate_clear, .irq_out);
